// file: design/ucm_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef UCM_CONSTS_SVH
`define UCM_CONSTS_SVH

`define UCM_OFF_CMD 8'h00
`define UCM_OFF_MODE 8'h04
`define UCM_OFF_IRQ_SET 8'h08
`define UCM_OFF_IRQ_CLR 8'h0c
`define UCM_OFF_IRQ_STATE 8'h10
`define UCM_OFF_FLAGS 8'h14
`define UCM_OFF_RX_HOLD 8'h18
`define UCM_OFF_TX_HOLD 8'h1c
`define UCM_OFF_BAUD 8'h20
`define UCM_OFF_RTO 8'h24
`define UCM_OFF_GUARD 8'h28
`define UCM_OFF_LIN_MODE 8'h54
`define UCM_OFF_LIN_ID 8'h58
`define UCM_OFF_LOCK_MODE 8'he4
`define UCM_OFF_LOCK_STAT 8'he8
`define UCM_OFF_REVISION 8'hfc

// command strobe bits
`define UCM_CMD_RX_RESET 2
`define UCM_CMD_TX_RESET 3
`define UCM_CMD_RX_ON 4
`define UCM_CMD_RX_OFF 5
`define UCM_CMD_TX_ON 6
`define UCM_CMD_TX_OFF 7
`define UCM_CMD_FLAGS_CLEAR 8
`define UCM_CMD_BREAK_START 9
`define UCM_CMD_BREAK_STOP 10
`define UCM_CMD_COUNTDOWN_RESTART 11
`define UCM_CMD_ADDRESS_NEXT 12
`define UCM_CMD_NEG_ACK_CLEAR 14
`define UCM_CMD_TIMEOUT_REARM 15
`define UCM_CMD_LINE_LOW 18
`define UCM_CMD_LINE_HIGH 19
`define UCM_CMD_LIN_ABORT 20
`define UCM_CMD_LIN_WAKE 21

// mode fields
`define UCM_MODE_SEL_LSB 0
`define UCM_CLK_SRC_LSB 4
`define UCM_CHAR_LEN_LSB 6
`define UCM_MODE_NINE_BIT 17
`define UCM_MODE_CLK_DRIVE 18
`define UCM_MODE_OVER8 19
`define UCM_MODE_NEG_ACK_FLAG_INHIBIT 20
`define UCM_MODE_SPI_MASTER 4'he
`define UCM_CLK_SRC_EXT 2'h3
`define UCM_PAR_LSB 9
`define UCM_PAR_MULTIDROP 2'h3

// flags register bits
`define UCM_FLG_BREAK_RX 2
`define UCM_FLG_OVERRUN 5
`define UCM_FLG_FRAMING 6
`define UCM_FLG_PARITY 7
`define UCM_FLG_TIMEOUT 8
`define UCM_FLG_NEG_ACK 13
`define UCM_FLG_LIN_DONE 15
`define UCM_FLG_ERR_MASK 32'h3e0000e4

// lock mode: enable bit
`define UCM_LOCK_ON_BIT 0

`define UCM_RESET_VAL 32'h00000000
`define UCM_MIN_STOP_BITS 12
`define UCM_WAKE_BITS 8

`endif

// file: design/ucm_pkg.sv
// types shared by the command and mode logic
package ucm_pkg;
  typedef enum logic [1:0] {
    UCM_BRK_IDLE,
    UCM_BRK_WAIT,
    UCM_BRK_SEND,
    UCM_BRK_GUARD
  } ucm_brk_t;
  typedef enum logic [0:0] {
    UCM_WAKE_IDLE,
    UCM_WAKE_SEND
  } ucm_wake_t;
endpackage

// file: design/ucm_regs.sv
// command strobes, mode register and register map of the serial transceiver
`timescale 1ns/100ps
`default_nettype none
`include "ucm_consts.svh"

// What this block does
// - written zero bits in commands do nothing
// - wake strobe sends LIN wakeup
// - abort strobe stops current LIN transfer
// - bit 19 drives line high or releases select
// - bit 18 drives line low or forces select
// - rearm reloads countdown and clears timeout flag
// - bit 14 clears negative acknowledge flag
// - address strobe marks next character as address in multidrop parity
// - restart aborts countdown until next character
// - break stop then guard ones, min 12 bits
// - break start after drain, ignored when breaking
// - flags clear wipes error and break flags
// - tx off beats tx on in same write
// - rx off beats rx on in same write
// - bits 3 and 2 reset tx and rx
// - mode register locked while write lock on
// - mode bit 20 inhibits negative acknowledge
// - mode bit 19 selects 8x or 16x oversampling
// - mode bit 18 drives clock pin unless external
// - mode bit 17 forces nine-bit characters
// - revision register reads implementation value
// - wakeup finish sets LIN transfer done
module ucm_regs #(
  parameter logic [31:0] REVISION = 32'h00000100, // arbitrary value
  parameter int RTO_WIDTH = 17
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic bit_tick_i,
  input wire logic char_rx_i,
  input wire logic tx_drained_i,
  input wire logic [8:0] err_set_i,
  input wire logic neg_ack_set_i,
  input wire logic [31:0] rx_char_i,
  output logic tx_enabled_o,
  output logic rx_enabled_o,
  output logic tx_reset_o,
  output logic rx_reset_o,
  output logic lin_abort_o,
  output logic send_address_o,
  output logic tx_load_o,
  output logic [8:0] tx_char_o,
  output logic break_line_o,
  output logic handshake_line_o,
  output logic neg_ack_inhibit_o,
  output logic over8_o,
  output logic clock_pin_drive_o,
  output logic nine_bit_chars_o,
  output logic timeout_flag_o
);
  import ucm_pkg::*;

  if (RTO_WIDTH < 1 || RTO_WIDTH > 32) begin : g_bad_rto_width
    $error("RTO_WIDTH out of range");
  end

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  logic [31:0] cmd;
  logic [31:0] mode;
  logic [31:0] imask;
  logic [31:0] flags;
  logic [31:0] baud;
  logic [31:0] rto;
  logic [31:0] guard;
  logic [31:0] lin_mode;
  logic [31:0] lin_id;
  logic [31:0] lock_mode;
  logic [31:0] lock_stat;
  logic [RTO_WIDTH-1:0] rto_cnt;
  logic rto_run;
  logic addr_pending;
  logic [31:0] guard_cnt;
  logic [3:0] wake_cnt;
  logic wake_done;
  logic lock_on;
  ucm_brk_t brk_state;
  ucm_wake_t wake_state;

  assign cmd = (wr_i && addr_i == `UCM_OFF_CMD) ? wdata_i : `UCM_RESET_VAL;
  assign lock_on = lock_mode[`UCM_LOCK_ON_BIT];

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= `UCM_RESET_VAL;
    end else if (rd_i) begin
      if (addr_i == `UCM_OFF_MODE) begin
        rdata_o <= mode;
      end else if (addr_i == `UCM_OFF_IRQ_STATE) begin
        rdata_o <= imask;
      end else if (addr_i == `UCM_OFF_FLAGS) begin
        rdata_o <= flags;
      end else if (addr_i == `UCM_OFF_RX_HOLD) begin
        rdata_o <= rx_char_i;
      end else if (addr_i == `UCM_OFF_BAUD) begin
        rdata_o <= baud;
      end else if (addr_i == `UCM_OFF_RTO) begin
        rdata_o <= rto;
      end else if (addr_i == `UCM_OFF_GUARD) begin
        rdata_o <= guard;
      end else if (addr_i == `UCM_OFF_LIN_MODE) begin
        rdata_o <= lin_mode;
      end else if (addr_i == `UCM_OFF_LIN_ID) begin
        rdata_o <= lin_id;
      end else if (addr_i == `UCM_OFF_LOCK_MODE) begin
        rdata_o <= lock_mode;
      end else if (addr_i == `UCM_OFF_LOCK_STAT) begin
        rdata_o <= lock_stat;
      end else if (addr_i == `UCM_OFF_REVISION) begin
        rdata_o <= REVISION;
      end else begin
        rdata_o <= `UCM_RESET_VAL;
      end
    end else begin
      rdata_o <= `UCM_RESET_VAL;
    end
  end

  // ------------------------------------------------------------
  // plain storage registers
  // ------------------------------------------------------------
  // zero after reset
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode <= `UCM_RESET_VAL;
      baud <= `UCM_RESET_VAL;
      rto <= `UCM_RESET_VAL;
      guard <= `UCM_RESET_VAL;
      lin_mode <= `UCM_RESET_VAL;
      lin_id <= `UCM_RESET_VAL;
      lock_mode <= `UCM_RESET_VAL;
      lock_stat <= `UCM_RESET_VAL;
      imask <= `UCM_RESET_VAL;
    end else if (wr_i) begin
      if (addr_i == `UCM_OFF_MODE || addr_i == `UCM_OFF_BAUD || addr_i == `UCM_OFF_RTO ||
          addr_i == `UCM_OFF_GUARD) begin
        if (lock_on) begin
          lock_stat <= {16'h0000, addr_i, 7'h00, 1'b1};
        end else if (addr_i == `UCM_OFF_MODE) begin
          mode <= wdata_i;
        end else if (addr_i == `UCM_OFF_BAUD) begin
          baud <= wdata_i;
        end else if (addr_i == `UCM_OFF_RTO) begin
          rto <= wdata_i;
        end else begin
          guard <= wdata_i;
        end
      end else if (addr_i == `UCM_OFF_LIN_MODE) begin
        lin_mode <= wdata_i;
      end else if (addr_i == `UCM_OFF_LIN_ID) begin
        lin_id <= wdata_i;
      end else if (addr_i == `UCM_OFF_LOCK_MODE) begin
        lock_mode <= wdata_i;
        lock_stat <= `UCM_RESET_VAL;
      end else if (addr_i == `UCM_OFF_IRQ_SET) begin
        imask <= imask | wdata_i;
      end else if (addr_i == `UCM_OFF_IRQ_CLR) begin
        imask <= imask & ~wdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // mode outputs
  // ------------------------------------------------------------
  // neg_ack_flag inhibit
  assign neg_ack_inhibit_o = mode[`UCM_MODE_NEG_ACK_FLAG_INHIBIT];
  assign over8_o = mode[`UCM_MODE_OVER8];
  assign clock_pin_drive_o = mode[`UCM_MODE_CLK_DRIVE] && (mode[5:4] != `UCM_CLK_SRC_EXT);
  assign nine_bit_chars_o = mode[`UCM_MODE_NINE_BIT];

  // ------------------------------------------------------------
  // enables and resets
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_enabled_o <= 1'b0;
      rx_enabled_o <= 1'b0;
    end else begin
      if (cmd[`UCM_CMD_TX_OFF]) begin
        tx_enabled_o <= 1'b0;
      end else if (cmd[`UCM_CMD_TX_ON]) begin
        tx_enabled_o <= 1'b1;
      end
      if (cmd[`UCM_CMD_RX_OFF]) begin
        rx_enabled_o <= 1'b0;
      end else if (cmd[`UCM_CMD_RX_ON]) begin
        rx_enabled_o <= 1'b1;
      end
    end
  end

  assign tx_reset_o = cmd[`UCM_CMD_TX_RESET];
  assign rx_reset_o = cmd[`UCM_CMD_RX_RESET];
  assign lin_abort_o = cmd[`UCM_CMD_LIN_ABORT];

  // ------------------------------------------------------------
  // handshake line / select
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      handshake_line_o <= 1'b0;
    end else if (cmd[`UCM_CMD_LINE_HIGH]) begin
      handshake_line_o <= 1'b1;
    // low, select forced in spi master
    end else if (cmd[`UCM_CMD_LINE_LOW]) begin
      handshake_line_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transmit holding and address marking
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_pending <= 1'b0;
      tx_load_o <= 1'b0;
      tx_char_o <= 9'h000;
      send_address_o <= 1'b0;
    end else begin
      tx_load_o <= wr_i && addr_i == `UCM_OFF_TX_HOLD;
      if (wr_i && addr_i == `UCM_OFF_TX_HOLD) begin
        tx_char_o <= wdata_i[8:0];
        send_address_o <= addr_pending;
        addr_pending <= 1'b0;
      end else if (cmd[`UCM_CMD_ADDRESS_NEXT] && mode[`UCM_PAR_LSB+2 -: 2] == `UCM_PAR_MULTIDROP) begin
        addr_pending <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // break sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      brk_state <= UCM_BRK_IDLE;
      guard_cnt <= 32'h00000000;
    end else begin
      case (brk_state)
        UCM_BRK_IDLE: begin
          if (cmd[`UCM_CMD_BREAK_START]) begin
            brk_state <= UCM_BRK_WAIT;
          end
        end
        UCM_BRK_WAIT: begin
          if (cmd[`UCM_CMD_BREAK_STOP]) begin
            brk_state <= UCM_BRK_IDLE;
          end else if (tx_drained_i) begin
            brk_state <= UCM_BRK_SEND;
          end
        end
        UCM_BRK_SEND: begin
          if (cmd[`UCM_CMD_BREAK_STOP]) begin
            brk_state <= UCM_BRK_GUARD;
            guard_cnt <= (guard > 32'(`UCM_MIN_STOP_BITS)) ? guard : 32'(`UCM_MIN_STOP_BITS);
          end
        end
        default: begin
          if (bit_tick_i) begin
            if (guard_cnt <= 32'h00000001) begin
              brk_state <= UCM_BRK_IDLE;
            end
            guard_cnt <= guard_cnt - 32'h00000001;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // LIN wakeup
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_state <= UCM_WAKE_IDLE;
      wake_cnt <= 4'h0;
      wake_done <= 1'b0;
    end else begin
      wake_done <= 1'b0;
      case (wake_state)
        UCM_WAKE_IDLE: begin
          if (cmd[`UCM_CMD_LIN_WAKE]) begin
            wake_state <= UCM_WAKE_SEND;
            wake_cnt <= 4'h0;
          end
        end
        default: begin
          if (cmd[`UCM_CMD_LIN_ABORT]) begin
            wake_state <= UCM_WAKE_IDLE;
          end else if (bit_tick_i) begin
            if (wake_cnt == 4'(`UCM_WAKE_BITS - 1)) begin
              wake_state <= UCM_WAKE_IDLE;
              wake_done <= 1'b1;
            end
            wake_cnt <= wake_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // dominant while breaking or waking
  assign break_line_o = (brk_state == UCM_BRK_SEND) || (wake_state == UCM_WAKE_SEND);

  // ------------------------------------------------------------
  // receive time-out counter
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rto_cnt <= '0;
      rto_run <= 1'b0;
    end else if (cmd[`UCM_CMD_TIMEOUT_REARM]) begin
      rto_cnt <= rto[RTO_WIDTH-1:0];
      rto_run <= rto[RTO_WIDTH-1:0] != '0;
    end else if (cmd[`UCM_CMD_COUNTDOWN_RESTART]) begin
      rto_run <= 1'b0;
    end else if (char_rx_i) begin
      rto_cnt <= rto[RTO_WIDTH-1:0];
      rto_run <= rto[RTO_WIDTH-1:0] != '0;
    end else if (rto_run && bit_tick_i) begin
      rto_cnt <= rto_cnt - 1'b1;
      if (rto_cnt <= 1) begin
        rto_run <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // status flags: set wins over clear, except that rearm or restart beats a timeout
  // ------------------------------------------------------------
  logic timeout_hit;
  assign timeout_hit = rto_run && bit_tick_i && rto_cnt == 1 && !cmd[`UCM_CMD_TIMEOUT_REARM] &&
                       !cmd[`UCM_CMD_COUNTDOWN_RESTART] && !char_rx_i;
  logic [31:0] err_set_vec;
  assign err_set_vec = {2'b00, err_set_i[8:4], 17'h00000, err_set_i[3:1], 2'b00, err_set_i[0], 2'b00};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags <= `UCM_RESET_VAL;
    end else begin
      flags <= ((flags & ~(cmd[`UCM_CMD_FLAGS_CLEAR] ? `UCM_FLG_ERR_MASK : 32'h0)) | err_set_vec);
      if (timeout_hit) begin
        flags[`UCM_FLG_TIMEOUT] <= 1'b1;
      end else if (cmd[`UCM_CMD_TIMEOUT_REARM] || cmd[`UCM_CMD_COUNTDOWN_RESTART]) begin
        flags[`UCM_FLG_TIMEOUT] <= 1'b0;
      end
      if (neg_ack_set_i && !mode[`UCM_MODE_NEG_ACK_FLAG_INHIBIT]) begin
        flags[`UCM_FLG_NEG_ACK] <= 1'b1;
      end else if (cmd[`UCM_CMD_NEG_ACK_CLEAR]) begin
        flags[`UCM_FLG_NEG_ACK] <= 1'b0;
      end
      if (wake_done) begin
        flags[`UCM_FLG_LIN_DONE] <= 1'b1;
      end else if (cmd[`UCM_CMD_FLAGS_CLEAR]) begin
        flags[`UCM_FLG_LIN_DONE] <= 1'b0;
      end
    end
  end

  assign timeout_flag_o = flags[`UCM_FLG_TIMEOUT];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  tx_off_wins_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd[`UCM_CMD_TX_OFF] |=> !tx_enabled_o) else $error("tx enabled after off");
  rx_off_wins_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd[`UCM_CMD_RX_OFF] |=> !rx_enabled_o) else $error("rx enabled after off");
  mode_locked_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == `UCM_OFF_MODE && lock_on) |=> $stable(mode)) else $error("locked mode changed");
  cmd_reads_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == `UCM_OFF_CMD) |=> rdata_o == 32'h0) else $error("command read nonzero");
  rearm_clears_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd[`UCM_CMD_TIMEOUT_REARM] |=> !timeout_flag_o) else $error("timeout not cleared");
  neg_ack_flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (cmd[`UCM_CMD_NEG_ACK_CLEAR] && !neg_ack_set_i) |=> !flags[`UCM_FLG_NEG_ACK]) else $error("neg_ack_flag kept");
  err_clear_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (cmd[`UCM_CMD_FLAGS_CLEAR] && err_set_i == 9'h0) |=> (flags & `UCM_FLG_ERR_MASK) == 32'h0)
    else $error("error flags kept");
  wake_done_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wake_done |=> flags[`UCM_FLG_LIN_DONE]) else $error("lin done not set");
  break_start_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (brk_state == UCM_BRK_IDLE && cmd[`UCM_CMD_BREAK_START]) |=> brk_state == UCM_BRK_WAIT)
    else $error("break not armed");
  revision_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == `UCM_OFF_REVISION) |=> rdata_o == REVISION) else $error("bad revision");
endmodule
`default_nettype wire

// file: testbench/ucm_far_model.sv
// model of the transceiver datapath that feeds events into the register block
`timescale 1ns/100ps
`default_nettype none
module ucm_far_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  output logic bit_tick_o,
  output logic char_rx_o,
  output logic tx_drained_o,
  output logic [8:0] err_set_o,
  output logic neg_ack_o,
  output logic [31:0] rx_char_o
);
  int cnt;
  initial begin
    char_rx_o = 1'b0;
    tx_drained_o = 1'b0;
    err_set_o = 9'h000;
    neg_ack_o = 1'b0;
    rx_char_o = 32'h00000000;
  end
  // short bit period keeps the break and timeout runs brief
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      bit_tick_o <= 1'b0;
    end else begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      bit_tick_o <= (cnt == TICK_DIV - 1);
    end
  end
  task automatic drain(input logic v);
    @(posedge ref_clk_i);
    tx_drained_o <= v;
  endtask
  task automatic pulse(input logic [8:0] e, input logic n, input logic c);
    @(posedge ref_clk_i);
    err_set_o <= e;
    neg_ack_o <= n;
    char_rx_o <= c;
    if (c) begin
      rx_char_o <= 32'h000001a5;
    end
    @(posedge ref_clk_i);
    err_set_o <= 9'h000;
    neg_ack_o <= 1'b0;
    char_rx_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the command and mode register block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ucm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, rx_char, r;
  logic bit_tick, char_rx, drained, neg_ack;
  logic [8:0] err_set, tx_char_o;
  logic tx_en, rx_en, tx_rst, rx_rst, lin_abt, snd_addr, tx_load, brk, hs;
  logic inh, ov8, ckd, nine, tmo;
  int fail_count = 0;
  int n_checks = 0;
  int i;
  logic [7:0] offs [15] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                            8'h20, 8'h24, 8'h28, 8'h54, 8'h58, 8'he4, 8'he8};
  always #50 ref_clk_i = ~ref_clk_i;
  ucm_far_model i_far (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bit_tick_o(bit_tick),
    .char_rx_o(char_rx), .tx_drained_o(drained), .err_set_o(err_set), .neg_ack_o(neg_ack),
    .rx_char_o(rx_char));
  ucm_regs i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_tick_i(bit_tick),
    .char_rx_i(char_rx), .tx_drained_i(drained), .err_set_i(err_set),
    .neg_ack_set_i(neg_ack), .rx_char_i(rx_char), .tx_enabled_o(tx_en),
    .rx_enabled_o(rx_en), .tx_reset_o(tx_rst), .rx_reset_o(rx_rst), .lin_abort_o(lin_abt),
    .send_address_o(snd_addr), .tx_load_o(tx_load), .tx_char_o(tx_char_o),
    .break_line_o(brk), .handshake_line_o(hs), .neg_ack_inhibit_o(inh), .over8_o(ov8),
    .clock_pin_drive_o(ckd), .nine_bit_chars_o(nine), .timeout_flag_o(tmo));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    foreach (offs[k]) begin
      rd(offs[k], r);
      chk(r, 32'h0);
    end
    rd(8'hfc, r);
    chk(r, 32'h00000100);
    rd(8'h30, r);
    chk(r, 32'h0);
    // reset and abort strobes are pulses of the write cycle only
    @(posedge ref_clk_i);
    addr_i <= 8'h00;
    wdata_i <= 32'h0010000c;
    wr_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({tx_rst, rx_rst, lin_abt}, 3'b111);
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({tx_rst, rx_rst, lin_abt}, 3'b000);
    wr(8'h00, 32'h00000050);
    chk({tx_en, rx_en}, 2'b11);
    wr(8'h00, 32'h0);
    chk({tx_en, rx_en}, 2'b11);
    wr(8'h00, 32'h000000a0);
    chk({tx_en, rx_en}, 2'b00);
    wr(8'h00, 32'h000000f0);
    chk({tx_en, rx_en}, 2'b00);
    wr(8'h04, 32'h001e0c00);
    chk({inh, ov8, ckd, nine}, 4'hf);
    rd(8'h04, r);
    chk(r, 32'h001e0c00);
    wr(8'h00, 32'h00001000);
    wr(8'h1c, 32'h00000155);
    chk({tx_load, snd_addr, tx_char_o}, {2'b11, 9'h155});
    wr(8'h1c, 32'h00000033);
    chk({tx_load, snd_addr, tx_char_o}, {2'b10, 9'h033});
    wr(8'h04, 32'h00000030);
    chk({inh, ov8, ckd, nine}, 4'h0);
    wr(8'h00, 32'h00001000);
    wr(8'h1c, 32'h000000aa);
    chk({tx_load, snd_addr, tx_char_o}, {2'b10, 9'h0aa});
    wr(8'h04, 32'h00040030);
    chk(ckd, 1'b0);
    for (i = 0; i < 2; i++) begin
      wr(8'h04, i ? 32'h0000000e : 32'h0);
      wr(8'h00, 32'h00080000);
      chk(hs, 1'b1);
      wr(8'h00, 32'h00040000);
      chk(hs, 1'b0);
    end
    i_far.pulse(9'h1ff, 1'b1, 1'b1);
    rd(8'h14, r);
    chk(r & 32'h3e0020e4, 32'h3e0020e4);
    rd(8'h18, r);
    chk(r, 32'h000001a5);
    wr(8'h00, 32'h00000100);
    rd(8'h14, r);
    chk(r & 32'h3e0020e4, 32'h00002000);
    wr(8'h00, 32'h00004000);
    rd(8'h14, r);
    chk(r & 32'h3e0020e4, 32'h0);
    wr(8'h00, 32'h00200000);
    chk(brk, 1'b1);
    for (i = 0; i < 200 && brk !== 1'b0; i++) @(negedge ref_clk_i);
    chk(i > 25 && i < 40, 1'b1);
    rd(8'h14, r);
    chk(r[15], 1'b1);
    wr(8'h00, 32'h00200000);
    chk(brk, 1'b1);
    wr(8'h00, 32'h00100000);
    chk(brk, 1'b0);
    // break waits for the transmit path to drain
    wr(8'h00, 32'h00000200);
    repeat (20) @(negedge ref_clk_i);
    chk(brk, 1'b0);
    i_far.drain(1'b1);
    for (i = 0; i < 20 && brk !== 1'b1; i++) @(negedge ref_clk_i);
    chk(brk, 1'b1);
    wr(8'h00, 32'h00000200);
    chk(brk, 1'b1);
    wr(8'h00, 32'h00000400);
    for (i = 0; i < 20 && brk !== 1'b0; i++) @(negedge ref_clk_i);
    chk(brk, 1'b0);
    for (i = 0; i < 200 && i_dut.brk_state != UCM_BRK_IDLE; i++) @(negedge ref_clk_i);
    chk(i > 40 && i < 52, 1'b1);
    wr(8'h24, 32'h00000004);
    wr(8'h00, 32'h00008000);
    for (i = 0; i < 400 && tmo !== 1'b1; i++) @(negedge ref_clk_i);
    chk(tmo, 1'b1);
    wr(8'h00, 32'h00008000);
    chk(tmo, 1'b0);
    for (i = 0; i < 400 && tmo !== 1'b1; i++) @(negedge ref_clk_i);
    chk(tmo, 1'b1);
    wr(8'h00, 32'h00000800);
    chk(tmo, 1'b0);
    repeat (100) @(negedge ref_clk_i);
    chk(tmo, 1'b0);
    i_far.pulse(9'h000, 1'b0, 1'b1);
    for (i = 0; i < 400 && tmo !== 1'b1; i++) @(negedge ref_clk_i);
    chk(tmo, 1'b1);
    wr(8'he4, 32'h00000001);
    wr(8'h04, 32'h00080000);
    rd(8'h04, r);
    chk(r, 32'h0000000e);
    rd(8'he8, r);
    chk(r, 32'h00000401);
    wr(8'he4, 32'h0);
    wr(8'h04, 32'h00080000);
    rd(8'h04, r);
    chk(r, 32'h00080000);
    wr(8'h04, 32'h00100000);
    i_far.pulse(9'h000, 1'b1, 1'b0);
    rd(8'h14, r);
    chk(r[13], 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
